// >>> src/fpd_cfg.svh
// Constants for the four-pair disconnect management block
`ifndef FPD_CFG_SVH
`define FPD_CFG_SVH
`define FPD_CMD_FAULT_CFG 8'h2d
`define FPD_CFG_RESET 8'h00
`define FPD_BIT_THR_SEL_LO 0
`define FPD_BIT_PCUT_LO 2
`define FPD_BIT_PCUT_MGMT_LO 4
`define FPD_BIT_LIM_MGMT_LO 6
`define FPD_CLK_MHZ 250
`define FPD_DROPOUT_US 300
`define FPD_PULSE_US 60
`define FPD_MA_4P5 16'd45
`define FPD_MA_6P5 16'd65
`define FPD_MA_75 16'd750
`define FPD_MA_30 16'd300
`define FPD_CLASS_HI 4'h5
`endif

// >>> src/fpd_pkg.sv
// Types for the four-pair disconnect management block
package fpd_pkg;
  // Operating mode of a port
  typedef enum logic [1:0] {
    FPD_MODE_MANUAL = 2'b00,
    FPD_MODE_SEMI = 2'b01,
    FPD_MODE_AUTO = 2'b11,
    FPD_MODE_DIAG = 2'b10
  } fpd_mode_type;
  // Turn-on event carrier for one channel pair
  typedef struct packed {
    logic on;
    logic four_pair;
    logic dual_sig;
    logic [3:0] assigned_class;
  } fpd_turnon_type;
  // Per-channel state of one pair
  typedef enum logic [1:0] {
    FPD_CH_OFF = 2'b00,
    FPD_CH_ON = 2'b01,
    FPD_CH_PARTIAL = 2'b10
  } fpd_state_type;
endpackage : fpd_pkg

// >>> src/fpd_ch_timer.sv
// Undercurrent duration counter of one channel
`timescale 1ns/1ps
`include "fpd_cfg.svh"
module fpd_ch_timer #(
  parameter int CW = 20
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic below,
  input wire logic [CW-1:0] limit,
  output logic expired
);
  import fpd_pkg::*;
  // Narrower counters cannot hold even a shortened dropout time
  if (CW < 8) begin : g_bad_cw
    $error("counter too narrow");
  end
  logic [CW-1:0] count; // Cycles of continuous undercurrent
  logic [CW-1:0] next_count;
  // -------------------------------------------------------------
  // Counter next state
  // -------------------------------------------------------------
  always_comb begin
    next_count = count;
    if (!below) begin
      next_count = '0;
    end else if (count < limit) begin
      next_count = count + 1'b1;
    end
  end
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end
  assign expired = below && (count >= limit);
  property p_clear;
    @(posedge ref_clk) disable iff (!rstn) !below |=> count == '0;
  endproperty
  a_clear: assert property (p_clear)
    else $error("counter not cleared");
endmodule : fpd_ch_timer

// >>> src/fpd_top.sv
// Per-pair disconnect management with the fault configuration register
//
// Contract
// - Summed power cut applies when enable set
// - Current-limit faults detected regardless of enable
// - Auto modes set summed enable for single-signature
// - Select bit picks 4.5mA or 6.5mA
// - Threshold select bits 1:0, reset zero
// - Dual signature sets select, per pair
// - Dual signature: low channel turns off alone
// - Single signature select from assigned class in auto modes
// - Class 0-4 low select: partial disconnect
// - Re-enable channel above 75 mA
// - Summed cut suspended in partial or low
// - Class 5-8: off when both low
// - Cleared select after turn-on uses 6.5mA
// - Manual mode: independent off and fault flag
// - Summed enable bits 3:2
// - Register at command 2Dh, read/write
`timescale 1ns/1ps
`include "fpd_cfg.svh"
module fpd_top #(
  parameter int NP = 2,
  parameter int CW = 20,
  parameter int DROP_CYC = `FPD_DROPOUT_US * `FPD_CLK_MHZ,
  parameter int DROP_MPS_CYC = (`FPD_DROPOUT_US + `FPD_PULSE_US)
                               * `FPD_CLK_MHZ
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [7:0] cmd_code,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_wdata,
  output logic [7:0] cmd_rdata,
  input wire fpd_pkg::fpd_mode_type mode,
  input wire fpd_pkg::fpd_turnon_type [NP-1:0] turnon,
  input wire logic [NP-1:0] turnoff,
  input wire logic [2*NP-1:0][15:0] ch_current,
  input wire logic [2*NP-1:0] overcurrent,
  input wire logic [NP-1:0] summed_over,
  output logic [2*NP-1:0] ch_enable,
  output logic [2*NP-1:0] current_limit_fault,
  output logic [NP-1:0] summed_cut,
  output logic [2*NP-1:0] disconnect_fault_flag,
  output logic [NP-1:0] partial
);
  import fpd_pkg::*;
  // The register holds select and enable bits for two pairs only
  if (NP != 2) begin : g_bad_np
    $error("two channel pairs fit the register");
  end
  // Both dropout limits must fit the duration counters
  if (DROP_MPS_CYC >= (1 << CW) || DROP_CYC >= (1 << CW)) begin : g_bad_cw
    $error("counter too narrow");
  end
  // -------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------
  // Threshold in tenths of mA chosen by the select bit
  function automatic logic [15:0] thr(input logic sel);
    thr = sel ? `FPD_MA_4P5 : `FPD_MA_6P5;
  endfunction : thr
  function automatic logic manual_like(input fpd_mode_type m);
    manual_like = (m == FPD_MODE_MANUAL) || (m == FPD_MODE_DIAG);
  endfunction : manual_like
  // -------------------------------------------------------------
  // State
  // -------------------------------------------------------------
  logic [7:0] fault_cfg; // Fault configuration register
  logic [7:0] next_fault_cfg;
  logic [NP-1:0] sig_single; // Single-signature pair powered
  logic [NP-1:0] next_sig_single;
  logic [NP-1:0] low_class; // Assigned class 0-4
  logic [NP-1:0] next_low_class;
  logic [NP-1:0] manual_on; // Powered in manual or diagnostic
  logic [NP-1:0] next_manual_on;
  logic [NP-1:0] next_partial;
  logic [2*NP-1:0] next_ch_enable;
  logic [2*NP-1:0] next_current_limit_fault;
  logic [NP-1:0] next_cut;
  logic [2*NP-1:0] next_disconnect_fault_flag;
  logic [7:0] next_rdata;
  logic [2*NP-1:0] below; // Channel under its threshold
  logic [2*NP-1:0] expired; // Held long enough to disconnect
  logic [2*NP-1:0] exp_mps;
  logic [2*NP-1:0] exp_drop;
  // Shared counter limit: manual pairs use the plain dropout time
  logic [2*NP-1:0][CW-1:0] lim;
  // -------------------------------------------------------------
  // Per-channel timers
  // -------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 2*NP; g++) begin : g_ch
      always_comb begin
        below[g] = ch_enable[g] &&
          (ch_current[g] < thr(fault_cfg[`FPD_BIT_THR_SEL_LO + g/2]));
        lim[g] = manual_on[g/2] ? CW'(DROP_CYC) : CW'(DROP_MPS_CYC);
      end
      fpd_ch_timer #(.CW(CW)) u_tmr (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .below(below[g]),
        .limit(lim[g]),
        .expired(expired[g])
      );
      assign exp_mps[g] = expired[g] && !manual_on[g/2];
      assign exp_drop[g] = expired[g] && manual_on[g/2];
    end
  endgenerate
  // -------------------------------------------------------------
  // Register access and pair control, next values
  // -------------------------------------------------------------
  always_comb begin
    next_fault_cfg = fault_cfg;
    next_sig_single = sig_single;
    next_low_class = low_class;
    next_manual_on = manual_on;
    next_partial = partial;
    next_ch_enable = ch_enable;
    next_disconnect_fault_flag = disconnect_fault_flag;
    next_cut = '0;
    // Host write at the documented command code
    if (cmd_write && cmd_code == `FPD_CMD_FAULT_CFG) begin
      next_fault_cfg = cmd_wdata;
    end
    next_rdata = (cmd_code == `FPD_CMD_FAULT_CFG) ? fault_cfg : 8'h00;
    // Limit faults ride every enabled channel, whatever the summed enable
    next_current_limit_fault = overcurrent & ch_enable;
    for (int p = 0; p < NP; p++) begin
      if (turnoff[p]) begin
        next_ch_enable[2*p +: 2] = 2'b00;
        next_partial[p] = 1'b0;
      end else if (turnon[p].on && turnon[p].four_pair) begin
        next_ch_enable[2*p +: 2] = 2'b11;
        next_partial[p] = 1'b0;
        next_sig_single[p] = !turnon[p].dual_sig;
        next_low_class[p] = turnon[p].assigned_class < `FPD_CLASS_HI;
        next_manual_on[p] = manual_like(mode);
        if (turnon[p].dual_sig) begin
          next_fault_cfg[`FPD_BIT_THR_SEL_LO + p] = 1'b1;
        end else if (!manual_like(mode)) begin
          next_fault_cfg[`FPD_BIT_THR_SEL_LO + p] =
            !(turnon[p].assigned_class < `FPD_CLASS_HI);
          next_fault_cfg[`FPD_BIT_PCUT_LO + p] = 1'b1;
          next_fault_cfg[`FPD_BIT_PCUT_MGMT_LO + p] = 1'b1;
          next_fault_cfg[`FPD_BIT_LIM_MGMT_LO + p] = 1'b1;
        end
      end else if (manual_on[p] || !sig_single[p]) begin
        // Independent channels
        for (int c = 0; c < 2; c++) begin
          if (exp_mps[2*p+c]) begin
            next_ch_enable[2*p+c] = 1'b0;
          end
          if (exp_drop[2*p+c]) begin
            next_ch_enable[2*p+c] = 1'b0;
            next_disconnect_fault_flag[2*p+c] = 1'b1;
          end
        end
      end else if (partial[p]) begin
        // Surviving channel either recovers the pair or times out
        for (int c = 0; c < 2; c++) begin
          if (ch_enable[2*p+c] && ch_current[2*p+c] > `FPD_MA_75) begin
            next_ch_enable[2*p +: 2] = 2'b11;
            next_partial[p] = 1'b0;
          end else if (exp_mps[2*p+c]) begin
            next_ch_enable[2*p +: 2] = 2'b00;
            next_partial[p] = 1'b0;
          end
        end
      end else if (ch_enable[2*p +: 2] == 2'b11) begin
        if (!fault_cfg[`FPD_BIT_THR_SEL_LO + p] && low_class[p]) begin
          if (below[2*p]) begin
            next_ch_enable[2*p] = 1'b0;
            next_partial[p] = 1'b1;
          end else if (below[2*p+1]) begin
            next_ch_enable[2*p+1] = 1'b0;
            next_partial[p] = 1'b1;
          end
        end else if (exp_mps[2*p] && exp_mps[2*p+1]) begin
          next_ch_enable[2*p +: 2] = 2'b00;
        end
      end
      // Summed cut only when enabled and both channels carry load
      if (fault_cfg[`FPD_BIT_PCUT_LO + p] && summed_over[p] &&
          !partial[p] && ch_current[2*p] >= `FPD_MA_30 &&
          ch_current[2*p+1] >= `FPD_MA_30) begin
        next_cut[p] = 1'b1;
      end
      if (next_cut[p]) begin
        next_ch_enable[2*p +: 2] = 2'b00;
        next_partial[p] = 1'b0;
      end
    end
  end
  // -------------------------------------------------------------
  // Registers
  // -------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      fault_cfg <= `FPD_CFG_RESET;
      sig_single <= '0;
      low_class <= '0;
      manual_on <= '0;
      partial <= '0;
      ch_enable <= '0;
      current_limit_fault <= '0;
      summed_cut <= '0;
      disconnect_fault_flag <= '0;
      cmd_rdata <= 8'h00;
    end else begin
      fault_cfg <= next_fault_cfg;
      sig_single <= next_sig_single;
      low_class <= next_low_class;
      manual_on <= next_manual_on;
      partial <= next_partial;
      ch_enable <= next_ch_enable;
      current_limit_fault <= next_current_limit_fault;
      summed_cut <= next_cut;
      disconnect_fault_flag <= next_disconnect_fault_flag;
      cmd_rdata <= next_rdata;
    end
  end
  // -------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------
  property p_cut_en;
    @(posedge ref_clk) disable iff (!rstn)
      summed_cut[0] |-> $past(fault_cfg[`FPD_BIT_PCUT_LO]);
  endproperty
  a_cut_en: assert property (p_cut_en) else $error("cut while off");
  // Limit faults follow every powered channel, summed enable or not
  property p_limit_fault;
    @(posedge ref_clk) disable iff (!rstn)
      (overcurrent & ch_enable) != '0
      |=> (current_limit_fault & $past(overcurrent & ch_enable)) ==
          $past(overcurrent & ch_enable);
  endproperty
  a_limit_fault: assert property (p_limit_fault)
    else $error("limit fault missed");
  property p_wr;
    @(posedge ref_clk) disable iff (!rstn)
      (cmd_write && cmd_code == `FPD_CMD_FAULT_CFG && turnon == '0)
      |=> fault_cfg == $past(cmd_wdata);
  endproperty
  a_wr: assert property (p_wr) else $error("write lost");
  property p_dual;
    @(posedge ref_clk) disable iff (!rstn)
      (turnon[0].on && turnon[0].four_pair && turnon[0].dual_sig &&
       !turnoff[0]) |=> fault_cfg[`FPD_BIT_THR_SEL_LO];
  endproperty
  a_dual: assert property (p_dual) else $error("dual select");
  // Pair checks, one copy per pair so every pair the bench uses is seen
  for (genvar q = 0; q < NP; q++) begin : g_pair_chk
    property p_part_cut;
      @(posedge ref_clk) disable iff (!rstn)
        partial[q] |=> !summed_cut[q];
    endproperty
    a_part_cut: assert property (p_part_cut)
      else $error("cut in partial");
    property p_manual_fault;
      @(posedge ref_clk) disable iff (!rstn)
        (exp_drop[2*q +: 2] != 2'b00 && !turnoff[q] && !turnon[q].on &&
         !next_cut[q])
        |=> (disconnect_fault_flag[2*q +: 2] &
             $past(exp_drop[2*q +: 2])) == $past(exp_drop[2*q +: 2]) &&
            (ch_enable[2*q +: 2] & $past(exp_drop[2*q +: 2])) == 2'b00;
    endproperty
    a_manual_fault: assert property (p_manual_fault)
      else $error("manual fault");
    property p_reen;
      @(posedge ref_clk) disable iff (!rstn)
        (partial[q] && !turnoff[q] && !turnon[q].on &&
         ((ch_enable[2*q] && ch_current[2*q] > `FPD_MA_75) ||
          (ch_enable[2*q+1] && ch_current[2*q+1] > `FPD_MA_75)))
        |=> ch_enable[2*q +: 2] == 2'b11;
    endproperty
    a_reen: assert property (p_reen)
      else $error("no re-enable");
  end
  property p_hi;
    @(posedge ref_clk) disable iff (!rstn)
      (turnon[0].on && turnon[0].four_pair && !turnon[0].dual_sig &&
       !manual_like(mode) && !turnoff[0])
      |=> fault_cfg[`FPD_BIT_PCUT_LO] && fault_cfg[`FPD_BIT_THR_SEL_LO] ==
          ($past(turnon[0].assigned_class) >= `FPD_CLASS_HI);
  endproperty
  a_hi: assert property (p_hi) else $error("auto setting");
endmodule : fpd_top

// >>> verif/fpd_pd_model.sv
// Powered device model: current drawn on each channel of both pairs
`timescale 1ns/1ps
module fpd_pd_model (
  input wire logic [3:0] ch_enable,
  input wire logic [3:0][15:0] load,
  output logic [3:0][15:0] ch_current
);
  // ----------------------------------------
  // Sense path
  // ----------------------------------------
  // An unpowered channel draws nothing, so its sensed current is zero
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      ch_current[i] = ch_enable[i] ? load[i] : 16'h0000;
    end
  end
endmodule : fpd_pd_model

// >>> verif/tb_top.sv
// Self-checking bench for the four-pair disconnect management block
`timescale 1ns/1ps
module tb_top;
  import fpd_pkg::*;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] cmd_code = 8'h2d;
  logic cmd_write = 1'b0;
  logic [7:0] cmd_wdata = 8'h00;
  logic [7:0] cmd_rdata;
  fpd_mode_type mode = FPD_MODE_AUTO;
  fpd_turnon_type [1:0] turnon = '0;
  logic [1:0] turnoff = 2'b00;
  logic [3:0][15:0] load = '0; // Load each channel asks of the model
  logic [3:0][15:0] ch_current;
  logic [3:0] overcurrent = 4'h0;
  logic [1:0] summed_over = 2'b00;
  logic [3:0] ch_enable, current_limit_fault, disconnect_fault_flag;
  logic [1:0] summed_cut, partial;
  int fails = 0;
  int samples_checked = 0;
  int cycles = 0;
  logic [7:0] v;
  // Short timer counts keep each disconnect to a few dozen cycles
  fpd_top #(.NP(2), .CW(20), .DROP_CYC(20), .DROP_MPS_CYC(30)) i_fpd_top (
    .ref_clk(ref_clk), .rstn(rstn), .cmd_code(cmd_code),
    .cmd_write(cmd_write), .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata),
    .mode(mode), .turnon(turnon), .turnoff(turnoff),
    .ch_current(ch_current), .overcurrent(overcurrent),
    .summed_over(summed_over), .ch_enable(ch_enable),
    .current_limit_fault(current_limit_fault), .summed_cut(summed_cut),
    .disconnect_fault_flag(disconnect_fault_flag), .partial(partial));
  fpd_pd_model i_fpd_pd_model (.ch_enable(ch_enable), .load(load),
    .ch_current(ch_current));
  // ----------------------------------------
  // Clock, timeout and verdict
  // ----------------------------------------
  initial begin
    forever #2 ref_clk = ~ref_clk;
  end
  // Whole run needs well under a thousand cycles; the ceiling catches hangs
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      conclude();
    end
  end
  task automatic conclude();
    if (fails == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : conclude
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(string name, logic [15:0] seen, logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic cyc(int n);
    repeat (n) @(negedge ref_clk);
  endtask : cyc
  // One write cycle; the code goes back to the register afterwards
  task automatic wr(logic [7:0] code, logic [7:0] d);
    cmd_code = code;
    cmd_wdata = d;
    cmd_write = 1'b1;
    cyc(1);
    cmd_write = 1'b0;
    cmd_code = 8'h2d;
  endtask : wr
  // Read data lands two edges after a write, one after the code
  task automatic rd(output logic [7:0] d);
    cyc(2);
    d = cmd_rdata;
  endtask : rd
  // Clear the pair first so each scenario starts from a known state
  task automatic ton(int p, logic dual, logic [3:0] cls, fpd_mode_type m);
    turnoff[p] = 1'b1;
    cyc(1);
    turnoff[p] = 1'b0;
    mode = m;
    turnon[p] = '{on: 1'b1, four_pair: 1'b1, dual_sig: dual,
      assigned_class: cls};
    cyc(1);
    turnon[p] = '0;
    cyc(2);
  endtask : ton
  task automatic wait_en(int p, logic [1:0] e, int n);
    for (int i = 0; i < n && ch_enable[2*p+:2] !== e; i++) cyc(1);
  endtask : wait_en
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reg();
    rd(v);
    chk("cfg_reset", v, 8'h00);
    wr(8'h2d, 8'h0c);
    rd(v);
    chk("cfg_write", v, 8'h0c);
    wr(8'h2e, 8'hff);
    rd(v);
    chk("cfg_other_code", v, 8'h0c);
    cmd_code = 8'h2e;
    cyc(2);
    chk("rdata_other", cmd_rdata, 8'h00);
    cmd_code = 8'h2d;
    wr(8'h2d, 8'h00);
  endtask : t_reg
  task automatic t_class_hi();
    load = {4{16'd500}};
    ton(0, 1'b0, 4'h6, FPD_MODE_SEMI);
    chk("hi_on", ch_enable[1:0], 2'b11);
    rd(v);
    chk("hi_cfg", v & 8'h05, 8'h05);
    // A limit fault still shows while the summed enable is set
    overcurrent[1] = 1'b1;
    cyc(2);
    chk("limit_fault_summed", current_limit_fault[1], 1'b1);
    overcurrent[1] = 1'b0;
    load[0] = 16'd200;
    summed_over[0] = 1'b1;
    cyc(5);
    chk("cut_low_current", ch_enable[1:0], 2'b11);
    load[0] = 16'd500;
    for (int i = 0; i < 10 && summed_cut[0] !== 1'b1; i++) cyc(1);
    chk("cut_pulse", summed_cut[0], 1'b1);
    summed_over[0] = 1'b0;
    cyc(2);
    chk("cut_off", ch_enable[1:0], 2'b00);
    ton(0, 1'b0, 4'h6, FPD_MODE_AUTO);
    load[0] = 16'd0;
    cyc(40);
    chk("hi_one_low", ch_enable[1:0], 2'b11);
    load[1] = 16'd0;
    wait_en(0, 2'b00, 40);
    chk("hi_both_low", ch_enable[1:0], 2'b00);
    // 5 mA sits between the two thresholds: kept at 4.5, dropped at 6.5
    load = {4{16'd50}};
    ton(0, 1'b0, 4'h6, FPD_MODE_AUTO);
    cyc(40);
    chk("hi_5ma_kept", ch_enable[1:0], 2'b11);
    wr(8'h2d, 8'h54);
    wait_en(0, 2'b00, 40);
    chk("hi_sel_cleared", ch_enable[1:0], 2'b00);
  endtask : t_class_hi
  task automatic t_partial();
    load = {4{16'd500}};
    ton(1, 1'b0, 4'h3, FPD_MODE_AUTO);
    load[2] = 16'd30;
    cyc(3);
    chk("partial_flag", partial[1], 1'b1);
    chk("partial_en", ch_enable[3:2], 2'b10);
    summed_over[1] = 1'b1;
    cyc(4);
    chk("partial_no_cut", ch_enable[3:2], 2'b10);
    summed_over[1] = 1'b0;
    load[2] = 16'd500;
    load[3] = 16'd800;
    wait_en(1, 2'b11, 10);
    chk("reenable", ch_enable[3:2], 2'b11);
    chk("partial_clear", partial[1], 1'b0);
  endtask : t_partial
  task automatic t_dual();
    load = {4{16'd500}};
    // Clear the select bit so only the turn-on can set it again
    wr(8'h2d, 8'h00);
    ton(0, 1'b1, 4'h3, FPD_MODE_AUTO);
    rd(v);
    chk("dual_sel", v & 8'h01, 8'h01);
    load[0] = 16'd30;
    cyc(20);
    load[0] = 16'd500;
    cyc(2);
    load[0] = 16'd30;
    cyc(20);
    chk("dual_restart", ch_enable[1:0], 2'b11);
    wait_en(0, 2'b10, 20);
    chk("dual_alone", ch_enable[1:0], 2'b10);
  endtask : t_dual
  task automatic t_manual();
    load = {4{16'd500}};
    ton(1, 1'b0, 4'h3, FPD_MODE_MANUAL);
    load[2] = 16'd0;
    wait_en(1, 2'b10, 30);
    chk("man_off", ch_enable[3:2], 2'b10);
    chk("man_flag", disconnect_fault_flag[3:2], 2'b01);
    overcurrent[3] = 1'b1;
    cyc(2);
    chk("limit_fault", current_limit_fault[3], 1'b1);
    overcurrent[3] = 1'b0;
    // Diagnostic mode behaves like manual: independent drop and flag
    ton(0, 1'b0, 4'h3, FPD_MODE_DIAG);
    load[1] = 16'd0;
    wait_en(0, 2'b01, 30);
    chk("diag_off", ch_enable[1:0], 2'b01);
    chk("diag_flag", disconnect_fault_flag[1:0], 2'b10);
  endtask : t_manual
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge ref_clk);
    @(negedge ref_clk);
    rstn = 1'b1;
    t_reg();
    t_class_hi();
    t_partial();
    t_dual();
    t_manual();
    conclude();
  end
endmodule : tb_top
